// [dual_counter_capture_regs.v]
`timescale 1ns/100ps
`default_nettype none
`include "counter_defs.vh"
module dual_counter_capture_regs (
   // clock and reset
   input  wire       clock,
   input  wire       rstn,
   // register bank access
   input  wire       reg_select,
   input  wire       reg_write,
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   // signal pins
   input  wire       port3_bit1_input,
   input  wire       port2_bit0_input,
   // mode and edge setup
   input  wire       demod_mode,
   input  wire       input_select,
   input  wire [1:0] edge_select,
   input  wire [1:0] glitch_width,
   input  wire       word_counter_run,
   // edge status
   input  wire       rising_clear,
   input  wire       falling_clear,
   output reg        rising_seen,
   output reg        falling_seen,
   // interrupt requests
   output wire       capture_irq,
   output wire       timeout_irq
);
   reg  [1:0]  rst_sync;
   wire        rst_n;
   reg         byte_counter_run;
   reg         single_pass;
   reg         time_out;
   reg  [1:0]  byte_counter_prescale;
   reg         capture_mask;
   reg         timeout_mask;
   reg  [7:0]  byte_counter_low_level_hold;
   reg  [7:0]  byte_counter_high_level_hold;
   reg  [7:0]  word_counter_hold_low_byte;
   reg  [7:0]  word_counter_hold_high_byte;
   reg  [7:0]  word_capture_low_byte;
   reg  [7:0]  word_capture_high_byte;
   reg  [7:0]  byte_capture_low_time;
   reg  [7:0]  byte_capture_high_time;
   reg  [7:0]  byte_counter;
   reg  [15:0] word_counter;
   reg  [2:0]  divider;
   wire        tick;
   wire        pos_edge;
   wire        neg_edge;
   wire        wr;
   wire        capture;
   wire        reach_zero;
   reg  [7:0]  next_rdata;

   // ================================================
   // prescale tick test
   function tick_due;
      input [2:0] div;
      input [1:0] sel;
      reg   [2:0] mask;
      begin
         mask = 3'h0;
         case (sel)
            2'h1:    mask = 3'h1;
            2'h2:    mask = 3'h3;
            2'h3:    mask = 3'h7;
            default: mask = 3'h0;
         endcase
         tick_due = ((div & mask) == mask);
      end
   endfunction

   // ================================================
   // reset release
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ================================================
   // input edges
   edge_qualifier u_edge (
      .clock            (clock),
      .rst_n            (rst_n),
      .port3_bit1_input (port3_bit1_input),
      .port2_bit0_input (port2_bit0_input),
      .input_select     (input_select),
      .edge_select      (edge_select),
      .glitch_width     (glitch_width),
      .pos_edge         (pos_edge),
      .neg_edge         (neg_edge)
   );

   assign wr         = reg_select && reg_write;
   assign capture    = demod_mode && byte_counter_run && (pos_edge || neg_edge);
   assign tick       = tick_due(divider, byte_counter_prescale);
   assign reach_zero = byte_counter_run && tick && !capture && (byte_counter == 8'h01);

   // ================================================
   // control register
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         byte_counter_run      <= 1'b0;
         single_pass           <= 1'b0;
         time_out              <= 1'b0;
         byte_counter_prescale <= 2'h0;
         capture_mask          <= 1'b0;
         timeout_mask          <= 1'b0;
      end else begin
         if (wr && reg_addr == `OFS_CONTROL) begin
            byte_counter_run      <= reg_wdata[`CTL_RUN_BIT];
            single_pass           <= reg_wdata[`CTL_SINGLE_BIT];
            byte_counter_prescale <= reg_wdata[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
            capture_mask          <= reg_wdata[`CTL_CAPMASK_BIT];
            timeout_mask          <= reg_wdata[`CTL_TOMASK_BIT];
         end else if (reach_zero && single_pass) begin
            byte_counter_run <= 1'b0;
         end
         if (reach_zero) begin
            time_out <= 1'b1;
         end else if (wr && reg_addr == `OFS_CONTROL && reg_wdata[`CTL_TIMEOUT_BIT]) begin
            time_out <= 1'b0;
         end
      end
   end

   // ================================================
   // hold registers
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         byte_counter_low_level_hold  <= `RST_BYTE;
         byte_counter_high_level_hold <= `RST_BYTE;
         word_counter_hold_low_byte   <= `RST_BYTE;
         word_counter_hold_high_byte  <= `RST_BYTE;
      end else if (wr) begin
         case (reg_addr)
            `OFS_BYTE_LO_HOLD: byte_counter_low_level_hold  <= reg_wdata;
            `OFS_BYTE_HI_HOLD: byte_counter_high_level_hold <= reg_wdata;
            `OFS_WORD_HOLD_LO: word_counter_hold_low_byte   <= reg_wdata;
            `OFS_WORD_HOLD_HI: word_counter_hold_high_byte  <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ================================================
   // counters, prescaler and captures
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         divider                <= 3'h0;
         byte_counter           <= `BYTE_RELOAD;
         word_counter           <= `RST_WORD;
         byte_capture_low_time  <= `RST_BYTE;
         byte_capture_high_time <= `RST_BYTE;
         word_capture_low_byte  <= `RST_BYTE;
         word_capture_high_byte <= `RST_BYTE;
      end else begin
         divider <= byte_counter_run ? divider + 3'h1 : 3'h0;
         if (capture) begin
            if (pos_edge) begin
               byte_capture_low_time <= byte_counter;
            end else begin
               byte_capture_high_time <= byte_counter;
            end
            word_capture_high_byte <= word_counter[15:8];
            word_capture_low_byte  <= word_counter[7:0];
            byte_counter           <= `BYTE_RELOAD;
         end else if (reach_zero) begin
            byte_counter <= `BYTE_RELOAD;
         end else if (byte_counter_run && tick) begin
            byte_counter <= byte_counter - 8'h01;
         end
         if (!word_counter_run || word_counter == 16'h0000) begin
            word_counter <= {word_counter_hold_high_byte, word_counter_hold_low_byte};
         end else begin
            word_counter <= word_counter - 16'h0001;
         end
      end
   end

   // ================================================
   // edge status flags, set beats clear
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rising_seen  <= 1'b0;
         falling_seen <= 1'b0;
      end else begin
         if (capture && pos_edge) begin
            rising_seen <= 1'b1;
         end else if (rising_clear) begin
            rising_seen <= 1'b0;
         end
         if (capture && neg_edge) begin
            falling_seen <= 1'b1;
         end else if (falling_clear) begin
            falling_seen <= 1'b0;
         end
      end
   end

   assign capture_irq = capture_mask && (rising_seen || falling_seen);
   assign timeout_irq = timeout_mask && time_out;

   // ================================================
   // read path
   always @* begin
      case (reg_addr)
         `OFS_CONTROL:      next_rdata = {byte_counter_run, single_pass, time_out,
                                          byte_counter_prescale, capture_mask, timeout_mask, 1'b0};
         `OFS_BYTE_LO_HOLD: next_rdata = byte_counter_low_level_hold;
         `OFS_BYTE_HI_HOLD: next_rdata = byte_counter_high_level_hold;
         `OFS_WORD_HOLD_LO: next_rdata = word_counter_hold_low_byte;
         `OFS_WORD_HOLD_HI: next_rdata = word_counter_hold_high_byte;
         `OFS_WORD_CAP_LO:  next_rdata = word_capture_low_byte;
         `OFS_WORD_CAP_HI:  next_rdata = word_capture_high_byte;
         `OFS_BYTE_CAP_LO:  next_rdata = byte_capture_low_time;
         `OFS_BYTE_CAP_HI:  next_rdata = byte_capture_high_time;
         default:           next_rdata = 8'h00;
      endcase
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_select) begin
         reg_rdata <= next_rdata;
      end
   end
endmodule // dual_counter_capture_regs
`default_nettype wire

// [counter_defs.vh]
`ifndef COUNTER_DEFS_VH
`define COUNTER_DEFS_VH
// ================================================
// register offsets
`define OFS_CONTROL       4'h0
`define OFS_BYTE_LO_HOLD  4'h4
`define OFS_BYTE_HI_HOLD  4'h5
`define OFS_WORD_HOLD_LO  4'h6
`define OFS_WORD_HOLD_HI  4'h7
`define OFS_WORD_CAP_LO   4'h8
`define OFS_WORD_CAP_HI   4'h9
`define OFS_BYTE_CAP_LO   4'ha
`define OFS_BYTE_CAP_HI   4'hb
// ================================================
// control field positions
`define CTL_RUN_BIT       7
`define CTL_SINGLE_BIT    6
`define CTL_TIMEOUT_BIT   5
`define CTL_PRESCALE_HI   4
`define CTL_PRESCALE_LO   3
`define CTL_CAPMASK_BIT   2
`define CTL_TOMASK_BIT    1
// ================================================
// reset values
`define RST_BYTE          8'h00
`define RST_WORD          16'h0000
`define BYTE_RELOAD       8'hff
// ================================================
// edge select codes
`define EDGE_RISING       2'h0
`define EDGE_FALLING      2'h1
// ================================================
// glitch widths in system clocks
`define GLITCH_W1         5'h04
`define GLITCH_W2         5'h08
`define GLITCH_W3         5'h10
`endif

// [edge_qualifier.v]
`timescale 1ns/100ps
`default_nettype none
`include "counter_defs.vh"
module edge_qualifier (
   // clock and reset
   input  wire       clock,
   input  wire       rst_n,
   // pins
   input  wire       port3_bit1_input,
   input  wire       port2_bit0_input,
   // setup
   input  wire       input_select,
   input  wire [1:0] edge_select,
   input  wire [1:0] glitch_width,
   // qualified edges
   output reg        pos_edge,
   output reg        neg_edge
);
   reg  [2:0] sync;
   reg        level;
   reg  [4:0] stable;
   wire       raw;
   wire       agree;
   reg  [4:0] need;

   // ================================================
   // pin select and synchroniser
   assign raw = input_select ? port2_bit0_input : port3_bit1_input;
   assign agree = (sync[1] == sync[2]);

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync <= 3'h0;
      end else begin
         sync <= {sync[1:0], raw};
      end
   end

   always @* begin
      case (glitch_width)
         2'h1:    need = `GLITCH_W1;
         2'h2:    need = `GLITCH_W2;
         2'h3:    need = `GLITCH_W3;
         default: need = 5'h00;
      endcase
   end

   // ================================================
   // glitch filter and edge pick
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         level    <= 1'b0;
         stable   <= 5'h00;
         pos_edge <= 1'b0;
         neg_edge <= 1'b0;
      end else begin
         pos_edge <= 1'b0;
         neg_edge <= 1'b0;
         if (!agree || sync[2] == level) begin
            stable <= 5'h00;
         end else if (stable >= need) begin
            level    <= sync[2];
            stable   <= 5'h00;
            pos_edge <= sync[2] && (edge_select != `EDGE_FALLING);
            neg_edge <= !sync[2] && (edge_select != `EDGE_RISING);
         end else begin
            stable <= stable + 5'h01;
         end
      end
   end
endmodule // edge_qualifier
`default_nettype wire

// [pin_source.sv]
`timescale 1ns/100ps
`default_nettype none
// ================================================
// pulse source on the two candidate input pins
module pin_source (
   // clock
   input  wire logic clock,
   // pins
   output var  logic port3_bit1_input,
   output var  logic port2_bit0_input
);
   initial begin
      port3_bit1_input = 1'b0;
      port2_bit0_input = 1'b0;
   end

   // high pulse of n clocks, edges at falling clock edges
   task automatic pulse(input logic on_port2, input int n);
      @(negedge clock);
      if (on_port2) begin
         port2_bit0_input = 1'b1;
      end else begin
         port3_bit1_input = 1'b1;
      end
      repeat (n) @(negedge clock);
      port2_bit0_input = 1'b0;
      port3_bit1_input = 1'b0;
   endtask
endmodule // pin_source
`default_nettype wire

// [counter_checker_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
// ================================================
// port checker
module counter_checker (
   // clock and reset
   input wire logic       clock,
   input wire logic       rstn,
   // register bank access
   input wire logic       reg_select,
   input wire logic       reg_write,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // pins and setup
   input wire logic       port3_bit1_input,
   input wire logic       port2_bit0_input,
   input wire logic       input_select,
   input wire logic [1:0] edge_select,
   input wire logic       rising_clear,
   input wire logic       falling_clear,
   // status
   input wire logic       rising_seen,
   input wire logic       falling_seen,
   input wire logic       capture_irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   wire logic pin = input_select ? port2_bit0_input : port3_bit1_input;

   a_hold_readback: assert property (reg_select && reg_write && reg_addr[3:2] == 2'b01
      ##1 reg_select && !reg_write && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("hold byte readback wrong");
   a_unmapped_zero: assert property (reg_select && !reg_write && (reg_addr > 4'hb ||
      (reg_addr != 4'h0 && reg_addr < 4'h4)) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_rdata_steady: assert property (!reg_select |=> $stable(reg_rdata)) else $error("read data moved");
   a_rise_pin_high: assert property ($rose(rising_seen) |-> pin) else $error("rising capture with pin low");
   a_fall_pin_low: assert property ($rose(falling_seen) |-> !pin) else $error("falling capture with pin high");
   a_rise_kind: assert property ($rose(rising_seen) |-> edge_select != 2'h1) else $error("rising not selected");
   a_fall_kind: assert property ($rose(falling_seen) |-> edge_select != 2'h0) else $error("falling not selected");
   a_rise_sticky: assert property (rising_seen && !rising_clear |=> rising_seen) else $error("rising flag lost");
   a_fall_clear: assert property ($fell(falling_seen) |-> $past(falling_clear)) else $error("falling flag lost");
   a_irq_cause: assert property (capture_irq |-> rising_seen || falling_seen) else $error("irq without capture");
   a_irq_rise_cause: assert property ($rose(capture_irq) |-> $rose(rising_seen) || $rose(falling_seen) ||
      $past(reg_select && reg_write && reg_addr == 4'h0)) else $error("irq rose without cause");
endmodule // counter_checker

bind dual_counter_capture_regs counter_checker checker_i (.clock(clock), .rstn(rstn), .reg_select(reg_select),
   .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .port3_bit1_input(port3_bit1_input), .port2_bit0_input(port2_bit0_input), .input_select(input_select),
   .edge_select(edge_select), .rising_clear(rising_clear), .falling_clear(falling_clear),
   .rising_seen(rising_seen), .falling_seen(falling_seen), .capture_irq(capture_irq));
`default_nettype wire

// [test_dual_counter_capture_regs.sv]
`timescale 1ns/100ps
`default_nettype none
// ================================================
// testbench
module test_dual_counter_capture_regs;
   logic       clock, rstn, reg_select, reg_write, demod_mode, input_select, word_counter_run;
   logic       rising_clear, falling_clear, rising_seen, falling_seen, capture_irq, timeout_irq;
   logic       port3_bit1_input, port2_bit0_input;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [1:0] edge_select, glitch_width;
   int         num_errors = 0;
   int         num_checks = 0;

   initial clock = 1'b0;
   always #25 clock = ~clock;

   dual_counter_capture_regs DUT (.clock(clock), .rstn(rstn), .reg_select(reg_select), .reg_write(reg_write),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port3_bit1_input(port3_bit1_input),
      .port2_bit0_input(port2_bit0_input), .demod_mode(demod_mode), .input_select(input_select),
      .edge_select(edge_select), .glitch_width(glitch_width), .word_counter_run(word_counter_run),
      .rising_clear(rising_clear), .falling_clear(falling_clear), .rising_seen(rising_seen),
      .falling_seen(falling_seen), .capture_irq(capture_irq), .timeout_irq(timeout_irq));
   pin_source src (.clock(clock), .port3_bit1_input(port3_bit1_input), .port2_bit0_input(port2_bit0_input));

   // ================================================
   // access and compare tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_select = 1'b1;
      reg_write = 1'b1;
      reg_addr = a;
      reg_wdata = d;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(negedge clock);
      reg_select = 1'b1;
      reg_write = 1'b0;
      reg_addr = a;
      @(negedge clock);
      check(reg_rdata, exp);
   endtask
   task automatic idle(input int n);
      @(negedge clock);
      reg_select = 1'b0;
      repeat (n) @(negedge clock);
   endtask
   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ================================================
   // tests
   initial begin
      {rstn, reg_select, reg_write, reg_addr, reg_wdata, demod_mode, input_select} = '0;
      {edge_select, glitch_width, word_counter_run, rising_clear, falling_clear} = '0;
      repeat (4) @(negedge clock);
      rstn = 1'b1;
      repeat (3) @(negedge clock);
      for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
      $display("test reset done");
      for (int a = 4; a < 8; a++) begin
         wr(a[3:0], 8'(8'h11 * a));
         rd(a[3:0], 8'(8'h11 * a));
      end
      for (int a = 8; a < 12; a++) begin
         wr(a[3:0], 8'h5a);
         rd(a[3:0], 8'h00);
      end
      $display("test registers done");
      wr(4'h0, 8'h3c);
      rd(4'h0, 8'h1c);
      wr(4'h0, 8'h40);
      rd(4'h0, 8'h40);
      wr(4'h0, 8'h82);
      idle(300);
      rd(4'h0, 8'ha2);
      check(timeout_irq, 1'b1);
      wr(4'h0, 8'h80);
      rd(4'h0, 8'ha0);
      check(timeout_irq, 1'b0);
      wr(4'h0, 8'ha0);
      rd(4'h0, 8'h80);
      wr(4'h0, 8'hc0);
      idle(300);
      rd(4'h0, 8'h60);
      wr(4'h0, 8'hb8);
      idle(300);
      rd(4'h0, 8'h98);
      $display("test control done");
      wr(4'h0, 8'h84);
      idle(0);
      demod_mode = 1'b1;
      edge_select = 2'h2;
      src.pulse(1'b0, 16);
      idle(20);
      check(rising_seen, 1'b1);
      check(falling_seen, 1'b1);
      check(capture_irq, 1'b1);
      rd(4'hb, 8'hf0);
      rd(4'h8, 8'h66);
      rd(4'h9, 8'h77);
      idle(0);
      {rising_clear, falling_clear} = 2'b11;
      @(negedge clock);
      {rising_clear, falling_clear} = 2'b00;
      check({rising_seen, falling_seen, capture_irq}, 8'h00);
      $display("test capture done");
      wr(4'h0, 8'h80);
      idle(0);
      input_select = 1'b1;
      edge_select = 2'h0;
      glitch_width = 2'h1;
      src.pulse(1'b1, 2);
      idle(30);
      check(rising_seen, 1'b0);
      src.pulse(1'b0, 16);
      idle(30);
      check(rising_seen, 1'b0);
      src.pulse(1'b1, 12);
      idle(30);
      check(rising_seen, 1'b1);
      check(falling_seen, 1'b0);
      check(capture_irq, 1'b0);
      edge_select = 2'h1;
      src.pulse(1'b1, 12);
      idle(30);
      check(falling_seen, 1'b1);
      $display("test edge filter done");
      conclude();
   end

   initial begin
      #300000;
      num_errors++;
      conclude();
   end
endmodule // test_dual_counter_capture_regs
`default_nettype wire
